// ==== design/spf_irq_flags.sv ====
// What this block does
// - 8-bit framing: tx flag after eighth bit
// - 9-bit framing: tx flag at stop start
// - Enabled set tx flag requests interrupt
// - Only software clears tx flag, by zero
// - Completed receive byte sets rx bit 0
// - Rx flag set at stop bit sample
// - Enabled rx flag requests interrupt
// - Rx flag held until software clears
//
// Implementation choices: the plain strobed port and the register addresses.
`include "spf_map.svh"
`default_nettype none
module spf_irq_flags #(
    parameter int unsigned AW = 4,
    parameter int unsigned DW = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DW-1:0] o_rdata,
    input wire logic i_tx_data8_done,
    input wire logic i_tx_stop_begin,
    input wire logic i_rx_stop_sample,
    output logic o_nine_bit_mode,
    output logic o_tx_done_flag,
    output logic o_rx_done_flag,
    output logic o_irq
);

    typedef struct packed {
        spf_pkg::spf_ctrl_s ctrl;
        spf_pkg::spf_flags_t mask;
        logic [DW-1:0] rdata;
    } spf_state_s;

    spf_state_s state_ff;
    spf_state_s nxt_state;

    logic tx_set;
    logic rx_set;
    logic flags_wr;
    logic evt_wr;
    logic [DW-1:0] rd_word;
    spf_pkg::spf_flags_t done_val;
    spf_pkg::spf_flags_t evt_val;

    // Refused at elaboration: the map needs four address bits, two flags
    if (AW < 4) begin
        $error("spf_irq_flags: AW must be at least 4");
    end
    if (DW < 2) begin
        $error("spf_irq_flags: DW must be at least 2");
    end

    function automatic logic addr_hit(
        input logic [AW-1:0] addr,
        input logic [3:0] off
    );
        addr_hit = (addr == AW'(off));
    endfunction

    spf_flag_if #(.W(2)) done_if ();
    spf_flag_if #(.W(2)) evt_if ();

    spf_flag_hold #(
        .W(2)
    ) u_done_hold (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .port(done_if.hold)
    );

    spf_flag_hold #(
        .W(2)
    ) u_evt_hold (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .port(evt_if.hold)
    );

    assign done_val = done_if.val;
    assign evt_val = evt_if.val;

    // Framing choice picks which transmit point marks the byte done
    assign tx_set = state_ff.ctrl.nine_bit ? i_tx_stop_begin
                                           : i_tx_data8_done;
    assign rx_set = i_rx_stop_sample;

    assign flags_wr = i_wr && addr_hit(i_addr, `SPF_OFF_FLAGS);
    assign evt_wr = i_wr && addr_hit(i_addr, `SPF_OFF_EVT);

    always_comb begin
        done_if.set = '0;
        done_if.set[`SPF_BIT_TX] = tx_set;
        done_if.set[`SPF_BIT_RX] = rx_set;
    end

    // Writing zero clears; hardware never clears on its own
    always_comb begin
        done_if.clr = '0;
        if (flags_wr) begin
            done_if.clr = ~i_wdata[1:0];
        end
    end

    // Lost events: a completion arriving while its flag is still up
    assign evt_if.set = done_if.set & done_val;
    assign evt_if.clr = evt_wr ? i_wdata[1:0] : 2'h0;

    always_comb begin
        rd_word = '0;
        if (addr_hit(i_addr, `SPF_OFF_CTRL)) begin
            rd_word[`SPF_CTRL_IEN] = state_ff.ctrl.irq_en;
            rd_word[`SPF_CTRL_NINE] = state_ff.ctrl.nine_bit;
        end else if (addr_hit(i_addr, `SPF_OFF_FLAGS)) begin
            rd_word[1:0] = done_val;
        end else if (addr_hit(i_addr, `SPF_OFF_EVT)) begin
            rd_word[1:0] = evt_val;
        end else if (addr_hit(i_addr, `SPF_OFF_MASK)) begin
            rd_word[1:0] = state_ff.mask;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        // Read data stands one cycle only, zero otherwise
        nxt_state.rdata = '0;
        if (i_rd) begin
            nxt_state.rdata = rd_word;
        end
        if (i_wr && addr_hit(i_addr, `SPF_OFF_CTRL)) begin
            nxt_state.ctrl.irq_en = i_wdata[`SPF_CTRL_IEN];
            nxt_state.ctrl.nine_bit = i_wdata[`SPF_CTRL_NINE];
        end
        if (i_wr && addr_hit(i_addr, `SPF_OFF_MASK)) begin
            nxt_state.mask = i_wdata[1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff.ctrl <= `SPF_RST_CTRL;
            state_ff.mask <= `SPF_RST_MASK;
            state_ff.rdata <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_rdata = state_ff.rdata;
    assign o_nine_bit_mode = state_ff.ctrl.nine_bit;
    assign o_tx_done_flag = done_val[`SPF_BIT_TX];
    assign o_rx_done_flag = done_val[`SPF_BIT_RX];

    // Flag line gated by enable; lost-event line gated by mask
    assign o_irq = (state_ff.ctrl.irq_en && (|done_val))
                   || (|(evt_val & state_ff.mask));

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    AST_TX8_SETS: assert property (
        !o_nine_bit_mode && i_tx_data8_done |=> o_tx_done_flag
    ) else $error("tx flag not set after eighth bit");

    AST_TX8_IGNORES_STOP: assert property (
        !o_nine_bit_mode && !i_tx_data8_done && !o_tx_done_flag
        |=> !o_tx_done_flag
    ) else $error("tx flag set off the eighth bit");

    AST_TX9_SETS: assert property (
        o_nine_bit_mode && i_tx_stop_begin |=> o_tx_done_flag
    ) else $error("tx flag not set at stop bit start");

    AST_TX9_NOT_EARLY: assert property (
        o_nine_bit_mode && !i_tx_stop_begin && !o_tx_done_flag
        |=> !o_tx_done_flag
    ) else $error("tx flag set too early in 9-bit framing");

    AST_TX_IRQ: assert property (
        o_tx_done_flag && state_ff.ctrl.irq_en |-> o_irq
    ) else $error("enabled tx flag gave no interrupt");

    AST_TX_HOLD: assert property (
        o_tx_done_flag && !(flags_wr && !i_wdata[`SPF_BIT_TX])
        |=> o_tx_done_flag
    ) else $error("tx flag cleared without software");

    AST_TX_FELL_BY_SW: assert property (
        $fell(o_tx_done_flag) |-> $past(flags_wr)
            && !$past(i_wdata[`SPF_BIT_TX])
    ) else $error("tx flag fell without a zero write");

    AST_RX_SETS: assert property (
        i_rx_stop_sample |=> o_rx_done_flag
    ) else $error("rx flag not set on received byte");

    AST_RX_TIMING: assert property (
        $rose(o_rx_done_flag) |-> $past(i_rx_stop_sample)
    ) else $error("rx flag rose without a stop sample");

    AST_RX_IRQ: assert property (
        $rose(o_rx_done_flag) && state_ff.ctrl.irq_en |-> o_irq
    ) else $error("rx flag rise gave no interrupt");

    AST_RX_HOLD: assert property (
        $fell(o_rx_done_flag) |-> $past(flags_wr)
            && !$past(i_wdata[`SPF_BIT_RX])
    ) else $error("rx flag cleared without software");

    AST_IRQ_QUIET: assert property (
        !state_ff.ctrl.irq_en && ((evt_val & state_ff.mask) == 2'h0)
        |-> !o_irq
    ) else $error("interrupt raised while disabled");

    AST_IRQ_NEEDS_FLAG: assert property (
        ((evt_val & state_ff.mask) == 2'h0) && done_val == 2'h0
        |-> !o_irq
    ) else $error("interrupt raised with no flag");

    AST_RX_LOST_EVT: assert property (
        i_rx_stop_sample && o_rx_done_flag |=> evt_val[`SPF_BIT_RX]
    ) else $error("repeated rx completion not recorded");

    AST_IRQ_ON_EVT: assert property (
        (evt_val & state_ff.mask) != 2'h0 |-> o_irq
    ) else $error("unmasked lost event gave no interrupt");

    AST_RDATA_ONE_CYCLE: assert property (
        !i_rd |=> o_rdata == '0
    ) else $error("read data outside its cycle");

    COV_TX8_IRQ: cover property (
        !o_nine_bit_mode && i_tx_data8_done ##1 o_irq
    );

    COV_TX9_IRQ: cover property (
        o_nine_bit_mode && i_tx_stop_begin ##1 o_irq
    );

    COV_RX_SERVICE: cover property (
        $rose(o_rx_done_flag) ##[1:20] $fell(o_rx_done_flag)
    );

    COV_SET_AND_CLEAR: cover property (
        i_rx_stop_sample && flags_wr && !i_wdata[`SPF_BIT_RX]
    );

endmodule
`default_nettype wire

// ==== pkg/spf_map.svh ====
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH

// Register offsets, byte addresses on the plain register port
`define SPF_OFF_CTRL 4'h0
`define SPF_OFF_FLAGS 4'h4
`define SPF_OFF_EVT 4'h8
`define SPF_OFF_MASK 4'hc

// Field positions in FLAGS, EVT and MASK
`define SPF_BIT_RX 0
`define SPF_BIT_TX 1

// Field positions in CTRL
`define SPF_CTRL_IEN 0
`define SPF_CTRL_NINE 1

// Reset values
`define SPF_RST_CTRL 2'h0
`define SPF_RST_MASK 2'h0
`define SPF_RST_FLAGS 2'h0

`endif

// ==== pkg/spf_pkg.sv ====
`default_nettype none
package spf_pkg;

    typedef struct packed {
        logic nine_bit;
        logic irq_en;
    } spf_ctrl_s;

    // Bit 1 transmit side, bit 0 receive side
    typedef logic [1:0] spf_flags_t;

endpackage
`default_nettype wire

// ==== pkg/spf_flag_if.sv ====
`default_nettype none
interface spf_flag_if #(
    parameter int unsigned W = 2
);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] val;

    modport ctl (
        output set,
        output clr,
        input val
    );

    modport hold (
        input set,
        input clr,
        output val
    );
endinterface
`default_nettype wire

// ==== design/spf_flag_hold.sv ====
`include "spf_map.svh"
`default_nettype none
module spf_flag_hold #(
    parameter int unsigned W = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    spf_flag_if.hold port
);

    typedef struct packed {
        logic [W-1:0] val;
    } spf_hold_s;

    spf_hold_s state_ff;
    spf_hold_s nxt_state;

    // Refused at elaboration, before any logic is built
    if (W < 1) begin
        $error("spf_flag_hold: W must be at least 1");
    end

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        nxt_state = state_ff;
        for (int i = 0; i < W; i++) begin
            if (port.set[i]) begin
                nxt_state.val[i] = 1'b1;
            end else if (port.clr[i]) begin
                nxt_state.val[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign port.val = state_ff.val;

    AST_HOLD_SET_WINS: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (port.set != '0) |=> ((port.val & $past(port.set)) == $past(port.set))
    ) else $error("flag set pulse was lost");

endmodule
`default_nettype wire

// ==== bench/spf_frame_model.sv ====
`default_nettype none
module spf_frame_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_tx_go,
    input wire logic i_rx_go,
    input wire logic i_nine,
    output logic o_tx_data8_done,
    output logic o_tx_stop_begin,
    output logic o_rx_stop_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock per bit keeps frames short
    logic [3:0] tcnt;
    logic [3:0] rcnt;
    logic [3:0] tstop;
    assign tstop = i_nine ? 4'ha : 4'h9;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tcnt <= 4'h0;
            rcnt <= 4'h0;
        end else begin
            if (i_tx_go) tcnt <= 4'h1;
            else if (tcnt == tstop) tcnt <= 4'h0;
            else if (tcnt != 4'h0) tcnt <= tcnt + 4'h1;
            if (i_rx_go) rcnt <= 4'h1;
            else if (rcnt == 4'ha) rcnt <= 4'h0;
            else if (rcnt != 4'h0) rcnt <= rcnt + 4'h1;
        end
    end
    // Both pulses come in either framing; the port must pick one
    assign o_tx_data8_done = (tcnt == 4'h8);
    assign o_tx_stop_begin = (tcnt == tstop);
    assign o_rx_stop_sample = (rcnt == 4'ha);
endmodule
`default_nettype wire

// ==== bench/serial_port_irq_flags_tb.sv ====
`default_nettype none
module serial_port_irq_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 0;
    logic i_rst_n = 0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 0;
    logic i_rd = 0;
    logic tx_go = 0;
    logic rx_go = 0;
    logic [7:0] o_rdata;
    logic o_nine, o_tx, o_rx, o_irq, p8, ps, pr;
    logic s8 = 0;
    logic ss = 0;
    logic sr = 0;
    logic [7:0] v;
    int n_fail = 0;
    int checked = 0;
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    spf_irq_flags dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_tx_data8_done(p8), .i_tx_stop_begin(ps),
        .i_rx_stop_sample(pr), .o_nine_bit_mode(o_nine),
        .o_tx_done_flag(o_tx), .o_rx_done_flag(o_rx), .o_irq(o_irq));
    spf_frame_model peer (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_tx_go(tx_go), .i_rx_go(rx_go), .i_nine(o_nine),
        .o_tx_data8_done(p8), .o_tx_stop_begin(ps),
        .o_rx_stop_sample(pr));
    // Sticky record of which frame pulses already went by
    always @(posedge i_sys_clk) begin
        s8 <= tx_go ? 1'b0 : (s8 | p8);
        ss <= tx_go ? 1'b0 : (ss | ps);
        sr <= rx_go ? 1'b0 : (sr | pr);
    end
    task finish_test();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk_b(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_l(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task go(input bit rx);
        @(posedge i_sys_clk);
        if (rx) rx_go <= 1'b1;
        else tx_go <= 1'b1;
        @(posedge i_sys_clk);
        rx_go <= 1'b0;
        tx_go <= 1'b0;
    endtask
    // Bounded wait for a flag to rise
    task wait_f(input bit rx);
        int i;
        for (i = 0; i < 40; i++) begin
            cyc(1);
            if ((rx ? o_rx : o_tx) === 1'b1) break;
        end
        if (i == 40) begin
            n_fail++;
            finish_test();
        end
    endtask
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        cyc(1);
        chk_l(o_irq, 1'b0);
        chk_l(o_tx, 1'b0);
        chk_l(o_rx, 1'b0);
        rd(4'h0, v); chk_b(v, 8'h00);
        rd(4'h4, v); chk_b(v, 8'h00);
        rd(4'hc, v); chk_b(v, 8'h00);
        rd(4'h2, v); chk_b(v, 8'h00);
        $display("test reset done");
        wr(4'h0, 8'h01);
        go(0); wait_f(0);
        chk_l(s8, 1'b1);
        chk_l(ss, 1'b0);
        chk_l(o_irq, 1'b1);
        cyc(12); chk_l(o_tx, 1'b1);
        wr(4'h4, 8'hff); chk_l(o_tx, 1'b1);
        wr(4'h4, 8'h01); chk_l(o_tx, 1'b0);
        chk_l(o_irq, 1'b0);
        $display("test tx eight done");
        wr(4'h0, 8'h03); chk_l(o_nine, 1'b1);
        go(0); wait_f(0);
        chk_l(ss, 1'b1);
        wr(4'h4, 8'h01);
        $display("test tx nine done");
        go(1); wait_f(1);
        chk_l(sr, 1'b1);
        rd(4'h4, v); chk_b(v, 8'h01);
        cyc(1);
        chk_b(o_rdata, 8'h00);
        chk_l(o_irq, 1'b1);
        cyc(12); chk_l(o_rx, 1'b1);
        // Second byte while unserviced marks a lost event
        go(1); cyc(14);
        rd(4'h8, v); chk_b(v, 8'h01);
        wr(4'h0, 8'h02); chk_l(o_irq, 1'b0);
        wr(4'hc, 8'h01); chk_l(o_irq, 1'b1);
        wr(4'h8, 8'h01); chk_l(o_irq, 1'b0);
        rd(4'h8, v); chk_b(v, 8'h00);
        wr(4'hc, 8'h00);
        $display("test rx done");
        go(0); wait_f(0);
        chk_l(o_irq, 1'b0);
        wr(4'h0, 8'h03); chk_l(o_irq, 1'b1);
        // Repeated tx completion while unserviced marks a lost event
        go(0);
        cyc(14);
        rd(4'h8, v);
        chk_b(v, 8'h02);
        chk_l(o_tx, 1'b1);
        wr(4'h8, 8'h02);
        rd(4'h8, v);
        chk_b(v, 8'h00);
        wr(4'h4, 8'h02); chk_l(o_rx, 1'b0);
        chk_l(o_irq, 1'b1);
        wr(4'h4, 8'h00); chk_l(o_irq, 1'b0);
        $display("test irq done");
        finish_test();
    end
endmodule
`default_nettype wire
